// >>> rtl/irq_controller.sv
// Two-level interrupt controller: enable and priority registers, polling,
// preemption tracking and vector hand-off to the core.
// Assumes the core presents SFR accesses and pulses take_i when it accepts a vector.
//
// Function
// RULE_01 - Primary priority bits per source, bit 7 reserved
// RULE_02 - Secondary priority bits for interval, supply, serial
// RULE_03 - Secondary enable bits for interval, supply, serial
// RULE_04 - Software writes zero to secondary bit 3
// RULE_05 - Secondary register at a9, resets a0, no bits
// RULE_06 - High request preempts low service routine
// RULE_07 - Simultaneous levels: high granted first
// RULE_08 - No preemption at same level
// RULE_09 - Fixed polling order within a level
// RULE_10 - Push program counter, load vector
// RULE_11 - Documented vector addresses per source
// RULE_12 - Watchdog interrupt mode vectors to 005b
// RULE_13 - Watchdog always high, ignores global enable
// RULE_14 - Watchdog interrupts only with nonzero timeout
// RULE_15 - Primary enable: global plus seven individual
// RULE_16 - Primary priority at b8, bit addressable, resets 00
// RULE_17 - Track levels in service, release on return
module irq_controller
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     arst_n_i,
    // Special-function register port
    input  wire irq_ctrl_pkg::sfr_req_t   sfr_req_i,
    input  wire logic                     sfr_bit_wr_i,
    input  wire logic [2:0]               sfr_bit_sel_i,
    input  wire logic                     sfr_bit_val_i,
    output logic [7:0]                    sfr_rdata_o,
    output logic                          sfr_hit_o,
    // Peripheral requests and watchdog configuration
    input  wire irq_ctrl_pkg::irq_sources_t sources_i,
    input  wire logic                     watchdog_irq_mode_i,
    input  wire logic [3:0]               watchdog_timeout_i,
    // Core side
    input  wire logic [15:0]              pc_i,
    input  wire logic                     take_i,
    input  wire logic                     reti_i,
    output irq_ctrl_pkg::irq_grant_t      grant_o,
    output logic                          push_pc_o,
    output logic [1:0]                    service_levels_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0]     primary_irq_enable;
        logic [7:0]     primary_irq_priority;
        logic [7:0]     secondary_irq_enable_priority;
        service_state_t svc;
        irq_grant_t     grant;
        logic           push;
        logic [7:0]     rdata;
    } state_t;

    state_t     q;
    state_t     d;
    logic [1:0] rst_sync_q;
    logic       rst_n;

    logic [NUM_SOURCES-1:0] req_v;
    logic [NUM_SOURCES-1:0] high_v;
    logic [NUM_SOURCES-1:0] qual_v;
    logic                   hit;
    logic                   hit_high;
    logic [3:0]             idx;
    logic                   global_irq_enable;
    logic                   eligible;
    logic                   in_low;
    logic                   in_high;

    function automatic logic [15:0] vector_of(input logic [3:0] s);
        case (s)
            4'(SRC_SUPPLY):   vector_of = VEC_SUPPLY;
            4'(SRC_WDOG):     vector_of = VEC_WDOG;
            4'(SRC_EXT0):     vector_of = VEC_EXT0;
            4'(SRC_ADC):      vector_of = VEC_ADC;
            4'(SRC_TMR0):     vector_of = VEC_TMR0;
            4'(SRC_EXT1):     vector_of = VEC_EXT1;
            4'(SRC_TMR1):     vector_of = VEC_TMR1;
            4'(SRC_SERIAL):   vector_of = VEC_SERIAL;
            4'(SRC_UART):     vector_of = VEC_UART;
            4'(SRC_TMR2):     vector_of = VEC_TMR2;
            4'(SRC_INTERVAL): vector_of = VEC_INTERVAL;
            default:          vector_of = VEC_EXT0;
        endcase
    endfunction

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] b,
                                           input logic x);
        logic [7:0] r;
        r    = v;
        r[b] = x;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops; kept apart from the state struct
    // because it is the one register that the internal reset must not clear
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Source qualification
    always_comb begin
        global_irq_enable = q.primary_irq_enable[GLOBAL_IRQ_ENABLE_BIT]; // see RULE_15
        req_v  = '0;
        high_v = '0;
        req_v[SRC_SUPPLY]   = sources_i.supply_monitor_request;
        req_v[SRC_WDOG]     = sources_i.watchdog_request & watchdog_irq_mode_i
                              & (watchdog_timeout_i != 4'h0); // see RULE_12, see RULE_14
        req_v[SRC_EXT0]     = sources_i.ext_zero_request;
        req_v[SRC_ADC]      = sources_i.converter_ready_request;
        req_v[SRC_TMR0]     = sources_i.timer_zero_overflow;
        req_v[SRC_EXT1]     = sources_i.ext_one_request;
        req_v[SRC_TMR1]     = sources_i.timer_one_overflow;
        req_v[SRC_SERIAL]   = sources_i.serial_port_request;
        req_v[SRC_UART]     = sources_i.uart_receive_flag | sources_i.uart_transmit_flag;
        req_v[SRC_TMR2]     = sources_i.timer_two_overflow | sources_i.timer_two_external_flag;
        req_v[SRC_INTERVAL] = sources_i.interval_request;
        // Individual enables gated by global enable, see RULE_15, see RULE_03
        qual_v = '0;
        qual_v[SRC_EXT0]   = q.primary_irq_enable[EXT_ZERO_BIT];
        qual_v[SRC_TMR0]   = q.primary_irq_enable[TIMER_ZERO_BIT];
        qual_v[SRC_EXT1]   = q.primary_irq_enable[EXT_ONE_BIT];
        qual_v[SRC_TMR1]   = q.primary_irq_enable[TIMER_ONE_BIT];
        qual_v[SRC_UART]   = q.primary_irq_enable[UART_BIT];
        qual_v[SRC_TMR2]   = q.primary_irq_enable[TIMER_TWO_BIT];
        qual_v[SRC_ADC]    = q.primary_irq_enable[CONVERTER_BIT];
        qual_v[SRC_SERIAL] = q.secondary_irq_enable_priority[SERIAL_PORT_ENABLE_BIT];
        qual_v[SRC_SUPPLY] = q.secondary_irq_enable_priority[SUPPLY_MONITOR_ENABLE_BIT];
        qual_v[SRC_INTERVAL] = q.secondary_irq_enable_priority[INTERVAL_ENABLE_BIT];
        qual_v = qual_v & {NUM_SOURCES{global_irq_enable}};
        qual_v[SRC_WDOG] = 1'b1; // see RULE_13
        // Levels per source, see RULE_01, see RULE_02
        high_v[SRC_EXT0]   = q.primary_irq_priority[EXT_ZERO_BIT];
        high_v[SRC_TMR0]   = q.primary_irq_priority[TIMER_ZERO_BIT];
        high_v[SRC_EXT1]   = q.primary_irq_priority[EXT_ONE_BIT];
        high_v[SRC_TMR1]   = q.primary_irq_priority[TIMER_ONE_BIT];
        high_v[SRC_UART]   = q.primary_irq_priority[UART_BIT];
        high_v[SRC_TMR2]   = q.primary_irq_priority[TIMER_TWO_BIT];
        high_v[SRC_ADC]    = q.primary_irq_priority[CONVERTER_BIT];
        high_v[SRC_SERIAL] = q.secondary_irq_enable_priority[SERIAL_PORT_LEVEL_BIT];
        high_v[SRC_SUPPLY] = q.secondary_irq_enable_priority[SUPPLY_MONITOR_LEVEL_BIT];
        high_v[SRC_INTERVAL] = q.secondary_irq_enable_priority[INTERVAL_LEVEL_BIT];
        high_v[SRC_WDOG]   = 1'b1; // see RULE_13
    end

    irq_poll_arbiter #(
        .N          (NUM_SOURCES)
    ) u_arbiter (
        .req_i      (req_v & qual_v),
        .high_i     (high_v),
        .hit_o      (hit),
        .hit_high_o (hit_high),
        .idx_o      (idx)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Preemption: high preempts low only, never equal, see RULE_06, see RULE_08
    always_comb begin
        in_low  = (q.svc == ST_LOW) || (q.svc == ST_BOTH);
        in_high = (q.svc == ST_HIGH) || (q.svc == ST_BOTH);
        if (in_high) begin
            eligible = 1'b0;
        end else if (in_low) begin
            eligible = hit_high;
        end else begin
            eligible = hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d          = q;
        d.push     = 1'b0;
        // Register writes, see RULE_05, see RULE_16
        if (sfr_req_i.wr) begin
            case (sfr_req_i.addr)
                PRIMARY_IRQ_ENABLE_ADDR:    d.primary_irq_enable = sfr_req_i.wdata;
                PRIMARY_IRQ_PRIORITY_ADDR:
                    d.primary_irq_priority = sfr_req_i.wdata & PRIMARY_PRIORITY_MASK;
                // Bit 3 and bit 7 keep their fixed values, see RULE_04
                SECONDARY_IRQ_EN_PRIO_ADDR:
                    d.secondary_irq_enable_priority = (sfr_req_i.wdata & SECONDARY_WRITE_MASK)
                        | (SECONDARY_IRQ_EN_PRIO_RESET & ~SECONDARY_WRITE_MASK);
                default: ;
            endcase
        end
        // Bit writes reach only bit-addressable registers, see RULE_16
        if (sfr_bit_wr_i) begin
            case (sfr_req_i.addr)
                PRIMARY_IRQ_ENABLE_ADDR:
                    d.primary_irq_enable = set_bit(q.primary_irq_enable, sfr_bit_sel_i,
                                                   sfr_bit_val_i);
                PRIMARY_IRQ_PRIORITY_ADDR:
                    d.primary_irq_priority = set_bit(q.primary_irq_priority, sfr_bit_sel_i,
                                                     sfr_bit_val_i) & PRIMARY_PRIORITY_MASK;
                default: ;
            endcase
        end
        // Read data
        case (sfr_req_i.addr)
            PRIMARY_IRQ_ENABLE_ADDR:    d.rdata = q.primary_irq_enable;
            PRIMARY_IRQ_PRIORITY_ADDR:  d.rdata = q.primary_irq_priority;
            SECONDARY_IRQ_EN_PRIO_ADDR: d.rdata = q.secondary_irq_enable_priority;
            default:                    d.rdata = 8'h00;
        endcase
        // Offer the winning vector until the core takes it, see RULE_10, see RULE_11
        d.grant.valid      = eligible & ~take_i;
        d.grant.vector     = vector_of(idx);
        d.grant.high_level = hit_high;
        d.grant.return_pc  = pc_i;
        // Service level tracking, see RULE_17
        if (take_i && q.grant.valid) begin
            d.push        = 1'b1; // see RULE_10
            d.grant.valid = 1'b0;
            if (q.grant.high_level) begin
                d.svc = in_low ? ST_BOTH : ST_HIGH;
            end else begin
                d.svc = ST_LOW;
            end
        end else if (reti_i) begin
            case (q.svc)
                ST_BOTH: d.svc = ST_LOW;
                ST_HIGH: d.svc = ST_IDLE;
                ST_LOW:  d.svc = ST_IDLE;
                default: d.svc = ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q.primary_irq_enable            <= PRIMARY_IRQ_ENABLE_RESET;
            q.primary_irq_priority          <= PRIMARY_IRQ_PRIORITY_RESET;
            q.secondary_irq_enable_priority <= SECONDARY_IRQ_EN_PRIO_RESET;
            q.svc                           <= ST_IDLE;
            q.grant                         <= '0;
            q.push                          <= 1'b0;
            q.rdata                         <= 8'h00;
        end else begin
            q.primary_irq_enable            <= d.primary_irq_enable;
            q.primary_irq_priority          <= d.primary_irq_priority;
            q.secondary_irq_enable_priority <= d.secondary_irq_enable_priority;
            q.svc                           <= d.svc;
            q.grant                         <= d.grant;
            q.push                          <= d.push;
            q.rdata                         <= d.rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        sfr_rdata_o      = q.rdata;
        sfr_hit_o        = (sfr_req_i.addr == PRIMARY_IRQ_ENABLE_ADDR)
                         | (sfr_req_i.addr == PRIMARY_IRQ_PRIORITY_ADDR)
                         | (sfr_req_i.addr == SECONDARY_IRQ_EN_PRIO_ADDR);
        grant_o          = q.grant;
        push_pc_o        = q.push;
        service_levels_o = {in_high, in_low};
    end
endmodule

// >>> rtl/irq_ctrl_pkg.sv
// Package for the two-level interrupt controller: register map, field positions,
// reset values, vectors and carrier structs.
// Assumes an 8-bit special-function register port driven by the core on sys_clk_i.
package irq_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register addresses and reset values
    localparam logic [7:0] PRIMARY_IRQ_ENABLE_ADDR    = 8'ha8;
    localparam logic [7:0] PRIMARY_IRQ_PRIORITY_ADDR  = 8'hb8;
    localparam logic [7:0] SECONDARY_IRQ_EN_PRIO_ADDR = 8'ha9;
    localparam logic [7:0] PRIMARY_IRQ_ENABLE_RESET   = 8'h00;
    localparam logic [7:0] PRIMARY_IRQ_PRIORITY_RESET = 8'h00;
    localparam logic [7:0] SECONDARY_IRQ_EN_PRIO_RESET = 8'ha0;
    localparam logic [7:0] PRIMARY_PRIORITY_MASK      = 8'h7f;
    localparam logic [7:0] SECONDARY_WRITE_MASK       = 8'h77;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT   = 7;
    localparam int CONVERTER_BIT           = 6;
    localparam int TIMER_TWO_BIT           = 5;
    localparam int UART_BIT                = 4;
    localparam int TIMER_ONE_BIT           = 3;
    localparam int EXT_ONE_BIT             = 2;
    localparam int TIMER_ZERO_BIT          = 1;
    localparam int EXT_ZERO_BIT            = 0;
    localparam int INTERVAL_LEVEL_BIT      = 6;
    localparam int SUPPLY_MONITOR_LEVEL_BIT = 5;
    localparam int SERIAL_PORT_LEVEL_BIT   = 4;
    localparam int INTERVAL_ENABLE_BIT     = 2;
    localparam int SUPPLY_MONITOR_ENABLE_BIT = 1;
    localparam int SERIAL_PORT_ENABLE_BIT  = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Sources in polling order, index 0 polled first
    localparam int NUM_SOURCES = 11;
    localparam int SRC_SUPPLY  = 0;
    localparam int SRC_WDOG    = 1;
    localparam int SRC_EXT0    = 2;
    localparam int SRC_ADC     = 3;
    localparam int SRC_TMR0    = 4;
    localparam int SRC_EXT1    = 5;
    localparam int SRC_TMR1    = 6;
    localparam int SRC_SERIAL  = 7;
    localparam int SRC_UART    = 8;
    localparam int SRC_TMR2    = 9;
    localparam int SRC_INTERVAL = 10;

    localparam logic [15:0] VEC_EXT0     = 16'h0003;
    localparam logic [15:0] VEC_TMR0     = 16'h000b;
    localparam logic [15:0] VEC_EXT1     = 16'h0013;
    localparam logic [15:0] VEC_TMR1     = 16'h001b;
    localparam logic [15:0] VEC_UART     = 16'h0023;
    localparam logic [15:0] VEC_TMR2     = 16'h002b;
    localparam logic [15:0] VEC_ADC      = 16'h0033;
    localparam logic [15:0] VEC_SERIAL   = 16'h003b;
    localparam logic [15:0] VEC_SUPPLY   = 16'h0043;
    localparam logic [15:0] VEC_INTERVAL = 16'h0053;
    localparam logic [15:0] VEC_WDOG     = 16'h005b;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic supply_monitor_request;
        logic watchdog_request;
        logic ext_zero_request;
        logic converter_ready_request;
        logic timer_zero_overflow;
        logic ext_one_request;
        logic timer_one_overflow;
        logic serial_port_request;
        logic uart_receive_flag;
        logic uart_transmit_flag;
        logic timer_two_overflow;
        logic timer_two_external_flag;
        logic interval_request;
    } irq_sources_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
        logic [15:0] return_pc;
        logic        high_level;
    } irq_grant_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b11,
        ST_BOTH = 2'b10
    } service_state_t;

endpackage

// >>> rtl/irq_poll_arbiter.sv
// Fixed-order polling arbiter: picks the first set bit of the high level, else of the low level.
// Assumes the request vector already gated by enables; level vectors arrive ungated.
module irq_poll_arbiter
    import irq_ctrl_pkg::*;
#(
    parameter int N = NUM_SOURCES
) (
    // Qualified requests and level per source
    input  wire logic [N-1:0] req_i,
    input  wire logic [N-1:0] high_i,
    // Winner
    output logic              hit_o,
    output logic              hit_high_o,
    output logic [3:0]        idx_o
);
    logic [N-1:0] hi_req;
    logic [N-1:0] lo_req;

    function automatic logic [4:0] first_set(input logic [N-1:0] v);
        logic [4:0] r;
        r = 5'h1f;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    always_comb begin
        hi_req     = req_i & high_i;
        lo_req     = req_i & ~high_i;
        hit_o      = |req_i;
        hit_high_o = |hi_req;
        // High level wins over low in the same cycle, see RULE_07
        if (|hi_req) begin
            idx_o = 4'(first_set(hi_req));
        end else begin
            // Fixed polling order within one level, see RULE_09
            idx_o = 4'(first_set(lo_req));
        end
    end
endmodule

// >>> verification/irq_controller_chk.sv
// Port checker for the two-level interrupt controller.
// Assumes it is bound to irq_controller and sees only that module's ports.
module irq_controller_chk
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic                     sys_clk_i,
    input wire logic                     arst_n_i,
    // Register port
    input wire irq_ctrl_pkg::sfr_req_t   sfr_req_i,
    input wire logic [7:0]               sfr_rdata_o,
    input wire logic                     sfr_hit_o,
    // Watchdog and core side
    input wire logic                     watchdog_irq_mode_i,
    input wire logic [3:0]               watchdog_timeout_i,
    input wire logic                     take_i,
    input wire logic                     reti_i,
    input wire irq_ctrl_pkg::irq_grant_t grant_o,
    input wire logic                     push_pc_o,
    input wire logic [1:0]               service_levels_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    wire logic tk = take_i && grant_o.valid;

    ////////////////////////////////////////////////////////////////////////////////
    a_push_after_take: assert property (tk |=> push_pc_o)
        else $error("no push after take");
    a_push_cause: assert property (push_pc_o |-> $past(tk))
        else $error("push without take");
    a_take_high_lvl: assert property (
        tk && grant_o.high_level |=> service_levels_o[1])
        else $error("high take not in service");
    a_high_blocks_all: assert property (service_levels_o[1] |-> !grant_o.valid)
        else $error("offer during high routine");
    a_low_blocks_low: assert property (
        service_levels_o[0] && grant_o.valid |-> grant_o.high_level)
        else $error("low offer during low routine");
    a_wdog_offer: assert property (grant_o.valid && grant_o.vector == VEC_WDOG |->
        grant_o.high_level && $past(watchdog_irq_mode_i) && $past(watchdog_timeout_i) != 4'h0)
        else $error("bad watchdog offer");
    a_levels_hold: assert property (!tk && !reti_i |=> $stable(service_levels_o))
        else $error("levels moved without cause");
    a_reti_release: assert property (service_levels_o == 2'b01 && reti_i && !tk |=>
        service_levels_o == 2'b00)
        else $error("low level not released");
    a_hit_decode: assert property (sfr_hit_o == (sfr_req_i.addr == 8'ha8 ||
        sfr_req_i.addr == 8'hb8 || sfr_req_i.addr == 8'ha9))
        else $error("bad address decode");
    a_second_fixed: assert property ($past(sfr_req_i.addr) == 8'ha9 |->
        sfr_rdata_o[7] && !sfr_rdata_o[3])
        else $error("secondary fixed bits wrong");
    a_prio_bit_seven: assert property (
        $past(sfr_req_i.addr) == 8'hb8 |-> !sfr_rdata_o[7])
        else $error("priority bit 7 set");
endmodule

bind irq_controller irq_controller_chk chk_i (.sys_clk_i, .arst_n_i, .sfr_req_i, .sfr_rdata_o,
    .sfr_hit_o, .watchdog_irq_mode_i, .watchdog_timeout_i, .take_i, .reti_i, .grant_o,
    .push_pc_o, .service_levels_o);

// >>> verification/irq_controller_tb_top.sv
// Testbench for the two-level interrupt controller.
// Assumes the core model and the bound checker are compiled alongside.
module irq_controller_tb_top
    import irq_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, bwr = 1'b0, bval = 1'b0, wmode = 1'b0, reti = 1'b0;
    logic [2:0] bsel = 3'h0;
    logic [3:0] wto = 4'h0, dly = 4'h0;
    logic [12:0] src = 13'h0;
    logic [15:0] pc = 16'h1234;
    sfr_req_t req = '0;
    logic [7:0] rdata;
    logic [1:0] lv;
    logic hit, take, push;
    irq_grant_t grant, got;
    int n_fail = 0, total_checks = 0;
    localparam logic [15:0] PV [10] = '{VEC_SUPPLY, VEC_EXT0, VEC_ADC, VEC_TMR0, VEC_EXT1,
        VEC_TMR1, VEC_SERIAL, VEC_UART, VEC_TMR2, VEC_INTERVAL};
    localparam int PB [10] = '{12, 10, 9, 8, 7, 6, 5, 4, 1, 0};

    always #2 clk = ~clk;
    irq_controller uut (.sys_clk_i(clk), .arst_n_i(arst_n), .sfr_req_i(req), .sfr_bit_wr_i(bwr),
        .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
        .sources_i(irq_sources_t'(src)), .watchdog_irq_mode_i(wmode),
        .watchdog_timeout_i(wto), .pc_i(pc), .take_i(take), .reti_i(reti), .grant_o(grant),
        .push_pc_o(push), .service_levels_o(lv));
    irq_core_model core (.clk_i(clk), .grant_i(grant), .take_o(take), .delay_i(dly),
        .got_o(got));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic v);
        @(negedge clk);
        req.addr = a;
        bsel = s;
        bval = v;
        bwr = 1'b1;
        @(negedge clk);
        bwr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        req.addr = a;
        @(negedge clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic ret();
        @(negedge clk);
        reti = 1'b1;
        @(negedge clk);
        reti = 1'b0;
        @(negedge clk);
    endtask
    task automatic quiet(input int n);
        logic s = 1'b0;
        repeat (n) begin
            @(negedge clk);
            s |= grant.valid;
        end
        chk({15'h0, s}, 16'h0);
    endtask
    // Waits for the push, judges what the core took, drops the source
    task automatic srv(input logic [15:0] e, input int cl, input logic rt);
        for (int i = 0; i < 40 && push !== 1'b1; i++) @(negedge clk);
        chk({15'h0, push}, 16'h1);
        chk(got.vector, e);
        chk(got.return_pc, pc);
        src[cl] = 1'b0;
        if (rt) ret();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(8'ha8, 8'h00);
        rd(8'hb8, 8'h00);
        rd(8'ha9, 8'ha0);
        rd(8'h55, 8'h00);
        chk({15'h0, hit}, 16'h0);
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h7f);
        bw(8'hb8, 3'h6, 1'b0);
        rd(8'hb8, 8'h3f);
        wr(8'ha9, 8'h77);
        rd(8'ha9, 8'hf7);
        bw(8'ha9, 3'h0, 1'b0);
        rd(8'ha9, 8'hf7);
        wr(8'ha9, 8'h07);
        wr(8'hb8, 8'h00);
        wr(8'ha8, 8'hff);
        $display("test regs done");
    endtask
    task automatic t_poll();
        src = 13'h17f3;
        for (int k = 0; k < 10; k++) srv(PV[k], PB[k], 1'b1);
        $display("test poll done");
    endtask
    task automatic t_pre();
        wr(8'hb8, 8'h04);
        pc = 16'h4321;
        dly = 4'h3;
        src[8] = 1'b1;
        srv(VEC_TMR0, 8, 1'b0);
        chk({14'h0, lv}, 16'h1);
        src[10] = 1'b1;
        quiet(12);
        src[7] = 1'b1;
        srv(VEC_EXT1, 7, 1'b0);
        chk({14'h0, lv}, 16'h3);
        ret();
        chk({14'h0, lv}, 16'h1);
        ret();
        srv(VEC_EXT0, 10, 1'b1);
        dly = 4'h0;
        src[10] = 1'b1;
        src[7] = 1'b1;
        srv(VEC_EXT1, 7, 1'b1);
        srv(VEC_EXT0, 10, 1'b1);
        $display("test preempt done");
    endtask
    task automatic t_wdog();
        bw(8'ha8, 3'h7, 1'b0);
        rd(8'ha8, 8'h7f);
        src[8] = 1'b1;
        quiet(10);
        src[8] = 1'b0;
        wmode = 1'b1;
        src[11] = 1'b1;
        quiet(10);
        wmode = 1'b0;
        wto = 4'h5;
        quiet(10);
        wmode = 1'b1;
        srv(VEC_WDOG, 11, 1'b0);
        chk({15'h0, got.high_level}, 16'h1);
        ret();
        $display("test watchdog done");
    endtask
    task automatic end_sim();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_regs();
        t_poll();
        t_pre();
        t_wdog();
        end_sim();
    end
    initial begin
        #20000;
        n_fail++;
        end_sim();
    end
endmodule

// >>> verification/irq_core_model.sv
// Core model: accepts an offered vector after a set delay and keeps what it took.
// Assumes one clock shared with the controller.
module irq_core_model
    import irq_ctrl_pkg::*;
(
    // Clock
    input  wire logic                     clk_i,
    // Controller side
    input  wire irq_ctrl_pkg::irq_grant_t grant_i,
    output logic                          take_o,
    // Bench side
    input  wire logic [3:0]               delay_i,
    output irq_ctrl_pkg::irq_grant_t      got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    initial take_o = 1'b0;
    initial got_o = '0;
    // Take held up to the accepting edge, then dropped
    always @(posedge clk_i) begin
        if (take_o) begin
            take_o <= 1'b0;
            if (grant_i.valid) got_o <= grant_i;
        end else if (grant_i.valid && cnt_q >= delay_i) begin
            take_o <= 1'b1;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= grant_i.valid ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule
